// ---- design/sss_defs.vh ----
// Constants for the synchronous slave serial port
`ifndef SSS_DEFS_VH
`define SSS_DEFS_VH
// ==========================================
// Register byte addresses
`define SSS_ADDR_RXCTL 5'h00
`define SSS_ADDR_TXCTL 5'h04
`define SSS_ADDR_BAUD 5'h08
`define SSS_ADDR_RXBUF 5'h0C
`define SSS_ADDR_TXHOLD 5'h10
`define SSS_ADDR_IRQST 5'h14
`define SSS_ADDR_IRQMSK 5'h18
`define SSS_ADDR_INTCTL 5'h1C
// ==========================================
// Field positions
`define SSS_B_SERIAL_PORT_ENABLE 7
`define SSS_B_RX9 6
`define SSS_B_SINGLE_RECEIVE_ENABLE 5
`define SSS_B_CONTINUOUS_RECEIVE_ENABLE 4
`define SSS_B_OVERRUN_ERROR_FLAG 1
`define SSS_B_RECEIVED_NINTH_BIT 0
`define SSS_B_CLOCK_SOURCE_SELECT 7
`define SSS_B_TX9 6
`define SSS_B_TXEN 5
`define SSS_B_SYNC 4
`define SSS_B_TRMT 1
`define SSS_B_TX9D 0
`define SSS_B_CLOCK_POLARITY_SELECT 4
`define SSS_B_GIE 0
`define SSS_B_PERIPHERAL_INTERRUPT_ENABLE 1
`define SSS_B_RECEIVE_INTERRUPT_ENABLE 2
`define SSS_B_TRANSMIT_INTERRUPT_ENABLE 3
`define SSS_B_RECEIVE_FLAG 4
`define SSS_B_TRANSMIT_FLAG 5
`define SSS_EV_RX 0
`define SSS_EV_TX 1
`define SSS_EV_OVR 2
// ==========================================
// Widths, counts and reset values
`define SSS_EV_W 3
`define SSS_BITS8 4'h8
`define SSS_BITS9 4'h9
`define SSS_CNT_ZERO 4'h0
`define SSS_CNT_ONE 4'h1
`define SSS_BYTE_ZERO 8'h00
`define SSS_WORD_ZERO 32'h00000000
`define SSS_EV_ZERO 3'h0
`define SSS_SR_ZERO 9'h000
`endif

// ---- design/sss_top.v ----
// Synchronous slave serial port with Avalon-MM register access
`timescale 1ns/1ps
// Notes on behaviour
// - Slave receive: listening while continuous-receive is set, single-receive ignored
// - Slave mode: sync and enable set, source clear
// - Ninth received bit in status, low eight buffered
// - Receive flag on complete character, interrupt if enabled
// - Overrun cleared by continuous-receive disable or port disable
// - Sleep receive moves word to buffer, wakes
// - Shifting in sleep only in slave mode
// - Shift registers run from external shift clock
// - Whole word in sets receive flag, wakes
// - Word out reloads from holding, sets transmit flag
// - Holding register write clears transmit flag unless the word goes straight to the shifter
// - Wake resumes after sleep; vector if global
// - Device drives data pin on master clocks
// - Two writes: first shifts, second waits buffered
`include "sss_defs.vh"

module sss_top (
   input wire clk_in,
   input wire rst_b_in,
   input wire [4:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output wire [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   input wire sleep_in,
   input wire shift_clock_pin_in,
   input wire shared_data_pin_in,
   output wire shared_data_pin_out,
   output wire shared_data_pin_oe_out,
   output wire irq_out,
   output wire wake_out,
   output wire isr_call_out
);

   // ==========================================
   // Registers
   reg [7:0] rxctl_r;
   reg [7:0] txctl_r;
   reg [7:0] baud_r;
   reg [3:0] intctl_r;
   reg [`SSS_EV_W-1:0] irqst_r;
   reg [`SSS_EV_W-1:0] irqmsk_r;

   // Bus answer
   reg wait_r;
   reg [31:0] rdata_r;

   // Link synchronisers, with stage-valid marks for the clock chain only
   reg ck_s1_r, ck_s2_r, ck_s3_r;
   reg ck_v1_r, ck_v2_r, ck_v3_r;
   reg dt_s1_r, dt_s2_r;

   // Receive side
   reg [8:0] rsr_r;
   reg [3:0] rcnt_r;
   reg [7:0] rxbuf_r;
   reg received_ninth_bit_r;
   reg receive_flag_r;
   reg overrun_error_flag_r;

   // Transmit side
   reg [7:0] thold_r;
   reg thold_full_r;
   reg [8:0] tsr_r;
   reg tsr_full_r;
   reg [3:0] tcnt_r;

   // Output flops
   reg dout_r;
   reg doe_r;
   reg irq_r;
   reg wake_r;
   reg isr_r;

   // ==========================================
   // Mode decode
   wire serial_port_enable = rxctl_r[`SSS_B_SERIAL_PORT_ENABLE];
   wire continuous_receive_enable = rxctl_r[`SSS_B_CONTINUOUS_RECEIVE_ENABLE];
   wire slave_mode = txctl_r[`SSS_B_SYNC] & serial_port_enable & ~txctl_r[`SSS_B_CLOCK_SOURCE_SELECT];
   // Only slave mode has an external clock, so only it keeps shifting in sleep
   wire link_run = slave_mode;
   // Receiver never idle while enabled; single-receive bit plays no part
   wire rx_on = link_run & continuous_receive_enable;
   // One data pin: transmit only while the receiver is off
   wire tx_on = link_run & ~continuous_receive_enable & txctl_r[`SSS_B_TXEN];
   // Frame length in link clocks
   wire [3:0] rx_bits = rxctl_r[`SSS_B_RX9] ? `SSS_BITS9 : `SSS_BITS8;
   wire [3:0] tx_bits = txctl_r[`SSS_B_TX9] ? `SSS_BITS9 : `SSS_BITS8;

   // ==========================================
   // Bus access decode
   wire acc = ~wait_r;
   wire wr_go = avs_write_in & acc & avs_byteenable_in[0];
   wire rd_go = avs_read_in & acc;
   wire wr_rxctl = wr_go & (avs_address_in == `SSS_ADDR_RXCTL);
   wire wr_txctl = wr_go & (avs_address_in == `SSS_ADDR_TXCTL);
   wire wr_baud = wr_go & (avs_address_in == `SSS_ADDR_BAUD);
   wire wr_thold = wr_go & (avs_address_in == `SSS_ADDR_TXHOLD);
   wire wr_irqmsk = wr_go & (avs_address_in == `SSS_ADDR_IRQMSK);
   wire wr_intctl = wr_go & (avs_address_in == `SSS_ADDR_INTCTL);
   wire rd_rxbuf = rd_go & (avs_address_in == `SSS_ADDR_RXBUF);
   wire rd_irqst = rd_go & (avs_address_in == `SSS_ADDR_IRQST);
   wire [7:0] wd = avs_writedata_in[7:0];
   // Port reset and overrun clear follow the written value at once
   wire serial_port_enable_off = wr_rxctl & ~wd[`SSS_B_SERIAL_PORT_ENABLE];
   wire continuous_receive_enable_off = wr_rxctl & ~wd[`SSS_B_CONTINUOUS_RECEIVE_ENABLE];

   // ==========================================
   // Link edge detect on synchronised shift clock
   // The chain resets low whatever the pin idles at, so no edge counts
   // until a real pin sample has reached the third stage
   wire ck_rise = ck_v3_r & ck_s2_r & ~ck_s3_r;
   wire ck_fall = ck_v3_r & ~ck_s2_r & ck_s3_r;
   // Idle high clock: shift out on rise, sample on fall; idle low swaps
   wire pol = baud_r[`SSS_B_CLOCK_POLARITY_SELECT];
   wire smp_edge = pol ? ck_rise : ck_fall;
   wire upd_edge = pol ? ck_fall : ck_rise;

   // Receive path
   wire [8:0] rsr_shift = {dt_s2_r, rsr_r[8:1]};
   wire rx_last = rx_on & smp_edge & (rcnt_r == rx_bits - `SSS_CNT_ONE);
   wire rx_load = rx_last & ~receive_flag_r & ~overrun_error_flag_r;
   // A word completing on a full buffer is lost; the old one stays
   wire rx_ovr = rx_last & (receive_flag_r | overrun_error_flag_r);
   // A 9-bit word lands fully in rsr; an 8-bit one sits one place high
   wire [8:0] rx_word = rxctl_r[`SSS_B_RX9] ? rsr_shift : {1'b0, rsr_shift[8:1]};

   // Transmit path
   wire tx_done = tx_on & upd_edge & tsr_full_r & (tcnt_r == tx_bits - `SSS_CNT_ONE);
   // A finishing word frees the shifter in the same cycle as a reload
   wire tsr_free = ~tsr_full_r | tx_done;
   wire tx_xfer = tsr_free & (thold_full_r | wr_thold) & tx_on;
   wire [7:0] tx_src = thold_full_r ? thold_r : wd;

   // Events and interrupt flags
   wire [`SSS_EV_W-1:0] ev_set = {rx_ovr, tx_xfer, rx_load};
   wire transmit_flag = ~thold_full_r;
   // Wake serves a sleeping core only; an awake core sees irq_out
   wire wake_nxt = sleep_in & intctl_r[`SSS_B_PERIPHERAL_INTERRUPT_ENABLE]
      & ((receive_flag_r & intctl_r[`SSS_B_RECEIVE_INTERRUPT_ENABLE]) | (transmit_flag & intctl_r[`SSS_B_TRANSMIT_INTERRUPT_ENABLE]));

   // ==========================================
   // Per-event status and pending bits
   // A setting event wins over the read that clears its status bit
   wire [`SSS_EV_W-1:0] irqst_nxt;
   wire [`SSS_EV_W-1:0] ev_pend;
   genvar ev_i;
   generate
      for (ev_i = 0; ev_i < `SSS_EV_W; ev_i = ev_i + 1) begin : g_ev
         assign irqst_nxt[ev_i] = ev_set[ev_i] | (irqst_r[ev_i] & ~rd_irqst);
         assign ev_pend[ev_i] = irqst_r[ev_i] & irqmsk_r[ev_i];
      end
   endgenerate

   // ==========================================
   // Read data mux
   reg [31:0] rdata_nxt;
   always @* begin
      // Unmapped addresses read as zero
      rdata_nxt = `SSS_WORD_ZERO;
      if (avs_address_in == `SSS_ADDR_RXCTL) begin
         rdata_nxt[7:0] = {rxctl_r[7:2], overrun_error_flag_r, received_ninth_bit_r};
      end else if (avs_address_in == `SSS_ADDR_TXCTL) begin
         rdata_nxt[7:0] = {txctl_r[7:2], ~tsr_full_r, txctl_r[`SSS_B_TX9D]};
      end else if (avs_address_in == `SSS_ADDR_BAUD) begin
         rdata_nxt[7:0] = baud_r;
      end else if (avs_address_in == `SSS_ADDR_RXBUF) begin
         rdata_nxt[7:0] = rxbuf_r;
      end else if (avs_address_in == `SSS_ADDR_IRQST) begin
         rdata_nxt[`SSS_EV_W-1:0] = irqst_r;
      end else if (avs_address_in == `SSS_ADDR_IRQMSK) begin
         rdata_nxt[`SSS_EV_W-1:0] = irqmsk_r;
      end else if (avs_address_in == `SSS_ADDR_INTCTL) begin
         rdata_nxt[7:0] = {2'h0, transmit_flag, receive_flag_r, intctl_r};
      end
   end

   // ==========================================
   // Bus handshake: one wait cycle, answer on the second edge
   // Registered answer keeps the read mux off the bus timing path
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wait_r <= 1'b1;
         rdata_r <= `SSS_WORD_ZERO;
      end else begin
         wait_r <= ~((avs_read_in | avs_write_in) & wait_r);
         if (wait_r) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // ==========================================
   // Control registers
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rxctl_r <= `SSS_BYTE_ZERO;
         txctl_r <= `SSS_BYTE_ZERO;
         baud_r <= `SSS_BYTE_ZERO;
         intctl_r <= `SSS_CNT_ZERO;
         irqmsk_r <= `SSS_EV_ZERO;
      end else begin
         // Read-only bits are not stored; the read mux supplies them
         if (wr_rxctl) begin
            rxctl_r <= {wd[7:2], 2'h0};
         end
         if (wr_txctl) begin
            txctl_r <= {wd[7:2], 1'b0, wd[`SSS_B_TX9D]};
         end
         if (wr_baud) begin
            baud_r <= {3'h0, wd[`SSS_B_CLOCK_POLARITY_SELECT], 4'h0};
         end
         if (wr_intctl) begin
            intctl_r <= wd[3:0];
         end
         if (wr_irqmsk) begin
            irqmsk_r <= wd[`SSS_EV_W-1:0];
         end
      end
   end

   // ==========================================
   // Synchronisers for the link pins
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         ck_v1_r <= 1'b0;
         ck_v2_r <= 1'b0;
         ck_v3_r <= 1'b0;
         dt_s1_r <= 1'b0;
         dt_s2_r <= 1'b0;
      end else begin
         ck_s1_r <= shift_clock_pin_in;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         // Valid marks trail the clock samples by the same three edges
         ck_v1_r <= 1'b1;
         ck_v2_r <= ck_v1_r;
         ck_v3_r <= ck_v2_r;
         dt_s1_r <= shared_data_pin_in;
         dt_s2_r <= dt_s1_r;
      end
   end

   // ==========================================
   // Receiver
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rsr_r <= `SSS_SR_ZERO;
         rcnt_r <= `SSS_CNT_ZERO;
         rxbuf_r <= `SSS_BYTE_ZERO;
         received_ninth_bit_r <= 1'b0;
         receive_flag_r <= 1'b0;
         overrun_error_flag_r <= 1'b0;
      end else if (serial_port_enable_off) begin
         rsr_r <= `SSS_SR_ZERO;
         rcnt_r <= `SSS_CNT_ZERO;
         receive_flag_r <= 1'b0;
         overrun_error_flag_r <= 1'b0;
      end else begin
         // A cut word restarts from bit zero, never completes late
         if (!rx_on || continuous_receive_enable_off) begin
            rcnt_r <= `SSS_CNT_ZERO;
         end else if (smp_edge) begin
            rsr_r <= rsr_shift;
            rcnt_r <= rx_last ? `SSS_CNT_ZERO : rcnt_r + `SSS_CNT_ONE;
         end
         if (rx_load) begin
            rxbuf_r <= rx_word[7:0];
            received_ninth_bit_r <= rx_word[8];
         end
         // New word wins over a read in the same cycle
         if (rx_load) begin
            receive_flag_r <= 1'b1;
         end else if (rd_rxbuf) begin
            receive_flag_r <= 1'b0;
         end
         if (rx_ovr) begin
            overrun_error_flag_r <= 1'b1;
         end else if (continuous_receive_enable_off) begin
            overrun_error_flag_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // Transmitter
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         thold_r <= `SSS_BYTE_ZERO;
         thold_full_r <= 1'b0;
         tsr_r <= `SSS_SR_ZERO;
         tsr_full_r <= 1'b0;
         tcnt_r <= `SSS_CNT_ZERO;
      end else if (serial_port_enable_off) begin
         // Port disable drops both words; software must write them again
         thold_full_r <= 1'b0;
         tsr_full_r <= 1'b0;
         tcnt_r <= `SSS_CNT_ZERO;
      end else begin
         if (tx_xfer) begin
            // Empty shifter takes the oldest word at once
            tsr_r <= {txctl_r[`SSS_B_TX9D], tx_src};
            tsr_full_r <= 1'b1;
            tcnt_r <= `SSS_CNT_ZERO;
         end else if (tx_done || !tx_on) begin
            tsr_full_r <= tx_done ? 1'b0 : tsr_full_r;
            tcnt_r <= `SSS_CNT_ZERO;
         end else if (upd_edge && tsr_full_r) begin
            tsr_r <= {1'b0, tsr_r[8:1]};
            tcnt_r <= tcnt_r + `SSS_CNT_ONE;
         end
         // A write while a word waits and the shifter stays busy is dropped
         if (wr_thold && thold_full_r && !tx_xfer) begin
            thold_r <= thold_r;
         end else if (wr_thold && !(tx_xfer && !thold_full_r)) begin
            thold_r <= wd;
            thold_full_r <= 1'b1;
         end else if (tx_xfer) begin
            thold_full_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // Event status and interrupt outputs
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irqst_r <= `SSS_EV_ZERO;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
         isr_r <= 1'b0;
      end else begin
         irqst_r <= irqst_nxt;
         irq_r <= |ev_pend;
         wake_r <= wake_nxt;
         isr_r <= wake_nxt & intctl_r[`SSS_B_GIE];
      end
   end

   // ==========================================
   // Data pin outputs
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dout_r <= 1'b0;
         doe_r <= 1'b0;
      end else begin
         // Drive only in transmit mode; otherwise the master owns the line
         dout_r <= tsr_r[0];
         doe_r <= tx_on;
      end
   end

   assign avs_readdata_out = rdata_r;
   assign avs_waitrequest_out = wait_r;
   assign shared_data_pin_out = dout_r;
   assign shared_data_pin_oe_out = doe_r;
   assign irq_out = irq_r;
   assign wake_out = wake_r;
   assign isr_call_out = isr_r;

endmodule

// ---- tb/sss_ext_master.sv ----
// Behavioural external master that clocks the serial link
`timescale 1ns/1ps
module sss_ext_master (
   output reg sck_out,
   output reg dout_out,
   input wire din_in
);
   initial begin
      sck_out = 1'b1;
      dout_out = 1'b1;
   end
   // Clock idles high and stands still between frames
   task xfer(input [8:0] d, input integer n, output [8:0] q);
      integer i;
      begin
         q = 9'h000;
         for (i = 0; i < n; i = i + 1) begin
            dout_out = d[i];
            #100 sck_out = 1'b0;
            // Late sample: slave updates well after the rising edge
            #100 q[i] = din_in;
            sck_out = 1'b1;
         end
         // Released line must not keep showing the last bit
         #100 dout_out = ~dout_out;
      end
   endtask
endmodule

// ---- tb/sss_top_sva.sv ----
// Port-level checker of the synchronous slave serial port
`timescale 1ns/1ps
`include "sss_defs.vh"
module sss_top_sva (
   input wire clk_in,
   input wire rst_b_in,
   input wire [4:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   input wire [31:0] avs_readdata_out,
   input wire avs_waitrequest_out,
   input wire shift_clock_pin_in,
   input wire shared_data_pin_out,
   input wire shared_data_pin_oe_out,
   input wire irq_out,
   input wire wake_out,
   input wire isr_call_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // ==========================================
   // Shadows of accepted register writes
   reg [7:0] rx_r, tx_r, int_r, msk_r;
   reg [3:0] sage_r, wage_r;
   reg sq_r;
   wire acc = !avs_waitrequest_out;
   wire [2:0] msk3 = msk_r[2:0];
   wire wr = avs_write_in && acc && avs_byteenable_in[0];
   wire slave = tx_r[4] && rx_r[7] && !tx_r[7];
   wire txm = tx_r[5] && !rx_r[4];
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_r <= 8'h00;
         tx_r <= 8'h00;
         int_r <= 8'h00;
         msk_r <= 8'h00;
         sq_r <= 1'b1;
         sage_r <= 4'hF;
         wage_r <= 4'hF;
      end else begin
         sq_r <= shift_clock_pin_in;
         sage_r <= (sq_r != shift_clock_pin_in) ? 4'h0 : sage_r + {3'h0, sage_r != 4'hF};
         wage_r <= wr ? 4'h0 : wage_r + {3'h0, wage_r != 4'hF};
         if (wr && avs_address_in == `SSS_ADDR_RXCTL) rx_r <= avs_writedata_in[7:0];
         if (wr && avs_address_in == `SSS_ADDR_TXCTL) tx_r <= avs_writedata_in[7:0];
         if (wr && avs_address_in == `SSS_ADDR_INTCTL) int_r <= avs_writedata_in[7:0];
         if (wr && avs_address_in == `SSS_ADDR_IRQMSK) msk_r <= avs_writedata_in[7:0];
      end
   end
   // ==========================================
   // Properties
   sequence s_rd_ans;
      avs_read_in && acc;
   endsequence
   sequence s_rd_rx;
      avs_read_in && acc && avs_address_in == `SSS_ADDR_RXCTL;
   endsequence
   AST_OE_SLAVE: assert property (shared_data_pin_oe_out |-> slave || $past(slave))
      else $error("data pin driven outside slave mode");
   AST_OE_TXMODE: assert property (shared_data_pin_oe_out |-> txm || $past(txm))
      else $error("data pin driven outside transmit mode");
   AST_ISR_WAKE: assert property (isr_call_out |-> wake_out && (int_r[0] || $past(int_r[0])))
      else $error("vector call without wake or global enable");
   AST_WAKE_PERIPHERAL_INTERRUPT_ENABLE: assert property (wake_out |-> int_r[1] || $past(int_r[1]))
      else $error("wake without peripheral enable");
   AST_IRQ_MASK: assert property (irq_out |-> msk3 != 3'h0 || $past(msk3) != 3'h0)
      else $error("interrupt with all events masked");
   AST_TX_EDGE: assert property ($changed(shared_data_pin_out) |-> sage_r <= 4'h8 || wage_r <= 4'h8)
      else $error("transmit bit changed without a shift clock edge");
   AST_RD_HIGH: assert property (s_rd_ans |-> avs_readdata_out[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   AST_OVERRUN_ERROR_FLAG_CLR: assert property (s_rd_rx |-> (rx_r[7] && rx_r[4]) || !avs_readdata_out[`SSS_B_OVERRUN_ERROR_FLAG])
      else $error("overrun kept with receiver off");
endmodule

// ---- tb/sss_top_tb.sv ----
// Self-checking bench of the synchronous slave serial port
`timescale 1ns/1ps
`include "sss_defs.vh"
module sss_top_tb;
   reg clk_in = 1'b0;
   reg rst_b_in = 1'b0;
   reg [4:0] addr = 5'h00;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg [31:0] wdata = 32'h00000000;
   reg sleep = 1'b0;
   wire [31:0] rdata;
   wire wait_req, sck, m_dout, d_out, d_oe, irq, wake, isr;
   wire pin = d_oe ? d_out : m_dout;
   integer errors = 0;
   integer comparisons = 0;
   reg [8:0] q;
   reg [31:0] r;
   always #12.5 clk_in = ~clk_in;
   sss_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
      .sleep_in(sleep), .shift_clock_pin_in(sck), .shared_data_pin_in(pin),
      .shared_data_pin_out(d_out), .shared_data_pin_oe_out(d_oe), .irq_out(irq),
      .wake_out(wake), .isr_call_out(isr));
   sss_ext_master master (.sck_out(sck), .dout_out(m_dout), .din_in(pin));
   // ==========================================
   // Shared tasks
   task print_verdict;
      begin
         $display("comparisons %0d errors %0d", comparisons, errors);
         if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task bus(input w, input [4:0] a, input [7:0] d);
      integer n;
      begin
         @(posedge clk_in);
         addr <= a;
         wdata <= {24'h000000, d};
         wr <= w;
         rd <= !w;
         n = 0;
         @(posedge clk_in);
         while (wait_req !== 1'b0 && n < 40) begin
            @(posedge clk_in);
            n = n + 1;
         end
         if (n >= 40) begin
            errors = errors + 1;
            $display("MISMATCH %0t bus answer timed out", $time);
         end
         r = rdata;
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask
   task rdchk(input [4:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 8'h00);
         chk(r, exp);
      end
   endtask
   task outchk(input [2:0] exp);
      begin
         repeat (10) @(posedge clk_in);
         chk({29'h0, irq, wake, isr}, {29'h0, exp});
      end
   endtask
   // ==========================================
   // Scenarios
   task t_regs;
      begin
         rdchk(`SSS_ADDR_RXCTL, 32'h0);
         rdchk(`SSS_ADDR_INTCTL, 32'h20);
         bus(1'b1, 5'h03, 8'hFF);
         rdchk(5'h03, 32'h0);
         $display("regs done");
      end
   endtask
   task t_rx;
      begin
         bus(1'b1, `SSS_ADDR_TXCTL, 8'h10);
         bus(1'b1, `SSS_ADDR_IRQMSK, 8'h05);
         bus(1'b1, `SSS_ADDR_INTCTL, 8'h07);
         bus(1'b1, `SSS_ADDR_RXCTL, 8'hB0);
         sleep <= 1'b1;
         master.xfer(9'h0A5, 8, q);
         outchk(3'b111);
         rdchk(`SSS_ADDR_IRQST, 32'h01);
         rdchk(`SSS_ADDR_RXBUF, 32'hA5);
         outchk(3'b000);
         $display("rx done");
      end
   endtask
   task t_ovr;
      begin
         master.xfer(9'h011, 8, q);
         master.xfer(9'h022, 8, q);
         repeat (10) @(posedge clk_in);
         rdchk(`SSS_ADDR_RXCTL, 32'hB2);
         rdchk(`SSS_ADDR_IRQST, 32'h05);
         bus(1'b1, `SSS_ADDR_RXCTL, 8'h80);
         rdchk(`SSS_ADDR_RXCTL, 32'h80);
         rdchk(`SSS_ADDR_RXBUF, 32'h11);
         $display("overrun done");
      end
   endtask
   task t_rx9;
      begin
         bus(1'b1, `SSS_ADDR_IRQMSK, 8'h00);
         bus(1'b1, `SSS_ADDR_RXCTL, 8'hD0);
         master.xfer(9'h13C, 9, q);
         outchk(3'b011);
         rdchk(`SSS_ADDR_RXCTL, 32'hD1);
         rdchk(`SSS_ADDR_RXBUF, 32'h3C);
         $display("rx9 done");
      end
   endtask
   task t_tx;
      begin
         bus(1'b1, `SSS_ADDR_RXCTL, 8'h80);
         bus(1'b1, `SSS_ADDR_TXCTL, 8'h30);
         bus(1'b1, `SSS_ADDR_INTCTL, 8'h0A);
         bus(1'b1, `SSS_ADDR_TXHOLD, 8'h5A);
         bus(1'b1, `SSS_ADDR_TXHOLD, 8'hC3);
         rdchk(`SSS_ADDR_INTCTL, 32'h0A);
         chk({31'h0, d_oe}, 32'h1);
         master.xfer(9'h000, 8, q);
         chk({23'h0, q}, 32'h5A);
         outchk(3'b010);
         rdchk(`SSS_ADDR_INTCTL, 32'h2A);
         sleep <= 1'b0;
         outchk(3'b000);
         sleep <= 1'b1;
         master.xfer(9'h000, 8, q);
         chk({23'h0, q}, 32'hC3);
         bus(1'b1, `SSS_ADDR_RXCTL, 8'h00);
         repeat (3) @(posedge clk_in);
         chk({31'h0, d_oe}, 32'h0);
         $display("tx done");
      end
   endtask
   initial begin
      #100000;
      errors = errors + 1;
      $display("MISMATCH %0t watchdog expired", $time);
      print_verdict;
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_regs;
      t_rx;
      t_ovr;
      t_rx9;
      t_tx;
      print_verdict;
   end
endmodule
bind sss_top sss_top_sva sva_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .shift_clock_pin_in(shift_clock_pin_in), .shared_data_pin_out(shared_data_pin_out),
   .shared_data_pin_oe_out(shared_data_pin_oe_out), .irq_out(irq_out),
   .wake_out(wake_out), .isr_call_out(isr_call_out));
